// >>> hw/sol_consts.svh
// timing, pattern and count constants for the out-of-band signalling ends
// Function
// - three signals: reset, initialise, wake, both directions
// - bursts of ALIGN or D24.3 dwords only
// - every burst lasts 160 OOB UI
// - reset/initialise gap is 480 OOB UI
// - gaps drive common-mode idle, not data
// - wake detection ends partial or slumber state
// - reset reported after four well-spaced bursts
// - gap below 175 or above 525 invalidates
// - host reset train has at least six bursts
// - line idle 525 ns after last burst
`ifndef SOL_CONSTS_SVH
`define SOL_CONSTS_SVH

// ==========================================================
// clock and link timing
`define SOL_CLK_PS        5000
`define SOL_BURST_PS      106700
`define SOL_GAP_PS        320000
`define SOL_WAKE_GAP_PS   106700
`define SOL_GAP_MIN_PS    175000
`define SOL_GAP_MAX_PS    525000
`define SOL_WAKE_MIN_PS   55000
`define SOL_BURST_CYC     8'((`SOL_BURST_PS + `SOL_CLK_PS - 1) / `SOL_CLK_PS)
`define SOL_GAP_CYC       8'((`SOL_GAP_PS + `SOL_CLK_PS - 1) / `SOL_CLK_PS)
`define SOL_WAKE_GAP_CYC  8'((`SOL_WAKE_GAP_PS + `SOL_CLK_PS - 1) / `SOL_CLK_PS)
`define SOL_GAP_MIN_CYC   8'((`SOL_GAP_MIN_PS + `SOL_CLK_PS - 1) / `SOL_CLK_PS)
`define SOL_GAP_MAX_CYC   8'(`SOL_GAP_MAX_PS / `SOL_CLK_PS)
`define SOL_WAKE_MIN_CYC  8'((`SOL_WAKE_MIN_PS + `SOL_CLK_PS - 1) / `SOL_CLK_PS)
`define SOL_TAIL_CYC      8'(`SOL_GAP_MAX_PS / `SOL_CLK_PS + 1)

// ==========================================================
// burst counts and patterns
`define SOL_TX_BURSTS     3'h6
`define SOL_DET_BURSTS    3'h4
`define SOL_ALIGN_DW      32'h7B4A4ABC
`define SOL_D243_DW       32'h78787878
`define SOL_IDLE_DW       32'h00000000

`endif

// >>> hw/sol_pkg.sv
// types and word decode shared by both link ends
`include "sol_consts.svh"
package sol_pkg;

   // ==========================================================
   // types
   typedef enum logic {SOL_OOB_RSTINIT, SOL_OOB_WAKE} sol_oob_t;
   typedef enum logic [1:0] {SOL_PM_ACTIVE, SOL_PM_PARTIAL, SOL_PM_SLUMBER} sol_pm_t;
   typedef enum logic [1:0] {SOL_TX_IDLE, SOL_TX_BURST, SOL_TX_GAP, SOL_TX_TAIL} sol_tx_st_t;

   // ==========================================================
   // burst content check
   function automatic logic sol_is_oob_word(input logic [31:0] dw);
      return (dw == `SOL_ALIGN_DW) || (dw == `SOL_D243_DW);
   endfunction

   // gap between bursts fits a reset/initialise train
   function automatic logic sol_gap_long(input logic [7:0] gap);
      return (gap >= `SOL_GAP_MIN_CYC) && (gap <= `SOL_GAP_MAX_CYC);
   endfunction

   // gap between bursts fits a wake train
   function automatic logic sol_gap_short(input logic [7:0] gap);
      return (gap >= `SOL_WAKE_MIN_CYC) && (gap < `SOL_GAP_MIN_CYC);
   endfunction

endpackage

// >>> hw/sol_link_if.sv
// serial link seen at burst level, one lane per direction
interface sol_link_if;
   // host to device lane
   logic        h2d_burst;
   logic [31:0] h2d_dword;
   // device to host lane
   logic        d2h_burst;
   logic [31:0] d2h_dword;

   modport host (
      output h2d_burst,
      output h2d_dword,
      input  d2h_burst,
      input  d2h_dword
   );

   modport dev (
      input  h2d_burst,
      input  h2d_dword,
      output d2h_burst,
      output d2h_dword
   );
endinterface

// >>> hw/sol_dev_end.sv
// device end: sends initialise and wake, detects reset and wake, power state
`include "sol_consts.svh"
module sol_dev_end (
   // clock and reset
   input  wire logic            clk_sys_i,
   input  wire logic            sys_rst_i,
   // link
   sol_link_if.dev              link,
   // user requests
   input  wire logic            send_init_i,
   input  wire logic            send_wake_i,
   input  wire logic            use_d243_i,
   input  wire logic            pm_partial_i,
   input  wire logic            pm_slumber_i,
   // status
   output logic                 rst_det_o,
   output logic                 rst_end_o,
   output logic                 wake_det_o,
   output logic                 wake_end_o,
   output logic                 tx_busy_o,
   output logic                 tx_done_o,
   output sol_pkg::sol_pm_t     pm_state_o
);
   import sol_pkg::*;

   // ==========================================================
   // receive detector
   logic       rx_on;
   logic       rx_start;
   logic       rx_on_d_ff;
   logic [7:0] idle_cnt_ff;
   logic [2:0] n_rst_ff;
   logic [2:0] n_wake_ff;
   logic       rst_det_ff;
   logic       wake_det_ff;
   logic       rst_end_ff;
   logic       wake_end_ff;
   logic       train_end;

   assign rx_on     = link.h2d_burst && sol_is_oob_word(link.h2d_dword);
   assign rx_start  = rx_on && !rx_on_d_ff;
   assign train_end = !rx_on && (idle_cnt_ff == `SOL_GAP_MAX_CYC);

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rx_on_d_ff <= 1'b0;
      end else begin
         rx_on_d_ff <= rx_on;
      end
   end

   // idle length since last burst, saturating past the longest gap
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         idle_cnt_ff <= `SOL_TAIL_CYC;
      end else if (rx_on) begin
         idle_cnt_ff <= 8'h00;
      end else if (idle_cnt_ff < `SOL_TAIL_CYC) begin
         idle_cnt_ff <= idle_cnt_ff + 8'h01;
      end
   end

   // burst counters per train kind
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         n_rst_ff  <= 3'h0;
         n_wake_ff <= 3'h0;
      end else if (train_end) begin
         n_rst_ff  <= 3'h0;
         n_wake_ff <= 3'h0;
      end else if (rx_start) begin
         if (idle_cnt_ff >= `SOL_TAIL_CYC) begin
            n_rst_ff  <= 3'h1;
            n_wake_ff <= 3'h1;
         end else if (sol_gap_long(idle_cnt_ff)) begin
            n_rst_ff  <= (n_rst_ff == `SOL_DET_BURSTS) ? n_rst_ff : n_rst_ff + 3'h1;
            n_wake_ff <= 3'h1;
         end else if (sol_gap_short(idle_cnt_ff)) begin
            n_wake_ff <= (n_wake_ff == `SOL_DET_BURSTS) ? n_wake_ff : n_wake_ff + 3'h1;
            n_rst_ff  <= 3'h1;
         end else begin
            n_rst_ff  <= 3'h1;
            n_wake_ff <= 3'h1;
         end
      end
   end

   // reset seen after four bursts, dropped on a bad gap or train end
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rst_det_ff <= 1'b0;
         rst_end_ff <= 1'b0;
      end else begin
         rst_end_ff <= train_end && rst_det_ff;
         if (train_end) begin
            rst_det_ff <= 1'b0;
         end else if (rx_start) begin
            rst_det_ff <= sol_gap_long(idle_cnt_ff) &&
                          (n_rst_ff >= `SOL_DET_BURSTS - 3'h1);
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wake_det_ff <= 1'b0;
         wake_end_ff <= 1'b0;
      end else begin
         wake_end_ff <= train_end && wake_det_ff;
         if (train_end) begin
            wake_det_ff <= 1'b0;
         end else if (rx_start) begin
            wake_det_ff <= sol_gap_short(idle_cnt_ff) &&
                           (n_wake_ff >= `SOL_DET_BURSTS - 3'h1);
         end
      end
   end

   // ==========================================================
   // pending requests, event set wins over take
   logic       pend_init_ff;
   logic       pend_wake_ff;
   logic       take;
   sol_oob_t   take_kind;

   assign take_kind = pend_init_ff ? SOL_OOB_RSTINIT : SOL_OOB_WAKE;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pend_init_ff <= 1'b0;
      end else if (send_init_i || rst_end_ff) begin
         pend_init_ff <= 1'b1;
      end else if (take && take_kind == SOL_OOB_RSTINIT) begin
         pend_init_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pend_wake_ff <= 1'b0;
      end else if (send_wake_i || wake_end_ff) begin
         pend_wake_ff <= 1'b1;
      end else if (take && take_kind == SOL_OOB_WAKE) begin
         pend_wake_ff <= 1'b0;
      end
   end

   // ==========================================================
   // transmit sequencer
   sol_tx_st_t state_ff;
   sol_tx_st_t nxt_state;
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic [2:0] nb_ff;
   logic [2:0] nxt_nb;
   sol_oob_t   kind_ff;
   logic       d243_ff;
   logic [7:0] gap_len;
   logic       tx_burst_ff;
   logic [31:0] tx_dword_ff;
   logic       busy_ff;
   logic       done_ff;

   assign gap_len = (kind_ff == SOL_OOB_WAKE) ? `SOL_WAKE_GAP_CYC : `SOL_GAP_CYC;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + 8'h01;
      nxt_nb    = nb_ff;
      take      = 1'b0;
      case (state_ff)
         SOL_TX_IDLE: begin
            nxt_cnt = 8'h00;
            if (pend_init_ff || pend_wake_ff) begin
               take      = 1'b1;
               nxt_state = SOL_TX_BURST;
               nxt_nb    = 3'h1;
            end
         end
         SOL_TX_BURST: begin
            if (cnt_ff == `SOL_BURST_CYC - 8'h01) begin
               nxt_cnt   = 8'h00;
               nxt_state = (nb_ff == `SOL_TX_BURSTS) ? SOL_TX_TAIL : SOL_TX_GAP;
            end
         end
         SOL_TX_GAP: begin
            if (cnt_ff == gap_len - 8'h01) begin
               nxt_cnt   = 8'h00;
               nxt_state = SOL_TX_BURST;
               nxt_nb    = nb_ff + 3'h1;
            end
         end
         SOL_TX_TAIL: begin
            if (cnt_ff == `SOL_TAIL_CYC - 8'h01) begin
               nxt_state = SOL_TX_IDLE;
            end
         end
         default: begin
            nxt_state = SOL_TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_ff <= SOL_TX_IDLE;
         cnt_ff   <= 8'h00;
         nb_ff    <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         nb_ff    <= nxt_nb;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         kind_ff <= SOL_OOB_RSTINIT;
         d243_ff <= 1'b0;
      end else if (take) begin
         kind_ff <= take_kind;
         d243_ff <= use_d243_i;
      end
   end

   // line drives pattern only inside a burst, idle level otherwise
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         tx_burst_ff <= 1'b0;
         tx_dword_ff <= `SOL_IDLE_DW;
      end else begin
         tx_burst_ff <= (nxt_state == SOL_TX_BURST);
         if (nxt_state == SOL_TX_BURST) begin
            tx_dword_ff <= d243_ff ? `SOL_D243_DW : `SOL_ALIGN_DW;
         end else begin
            tx_dword_ff <= `SOL_IDLE_DW;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != SOL_TX_IDLE);
         done_ff <= (state_ff == SOL_TX_TAIL) && (nxt_state == SOL_TX_IDLE);
      end
   end

   // ==========================================================
   // power state
   sol_pm_t pm_ff;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pm_ff <= SOL_PM_ACTIVE;
      end else if (wake_det_ff || rst_det_ff) begin
         pm_ff <= SOL_PM_ACTIVE;
      end else if (take && take_kind == SOL_OOB_WAKE) begin
         pm_ff <= SOL_PM_ACTIVE;
      end else if (pm_ff == SOL_PM_ACTIVE && !busy_ff) begin
         if (pm_slumber_i) begin
            pm_ff <= SOL_PM_SLUMBER;
         end else if (pm_partial_i) begin
            pm_ff <= SOL_PM_PARTIAL;
         end
      end
   end

   // ==========================================================
   // outputs
   assign link.d2h_burst = tx_burst_ff;
   assign link.d2h_dword = tx_dword_ff;
   assign rst_det_o      = rst_det_ff;
   assign rst_end_o      = rst_end_ff;
   assign wake_det_o     = wake_det_ff;
   assign wake_end_o     = wake_end_ff;
   assign tx_busy_o      = busy_ff;
   assign tx_done_o      = done_ff;
   assign pm_state_o     = pm_ff;
endmodule

// >>> hw/sol_host_end.sv
// host end: sends reset and wake, detects initialise and wake
`include "sol_consts.svh"
module sol_host_end (
   // clock and reset
   input  wire logic  clk_sys_i,
   input  wire logic  sys_rst_i,
   // link
   sol_link_if.host   link,
   // user requests
   input  wire logic  send_reset_i,
   input  wire logic  send_wake_i,
   input  wire logic  use_d243_i,
   // status
   output logic       init_det_o,
   output logic       init_end_o,
   output logic       wake_det_o,
   output logic       wake_end_o,
   output logic       tx_busy_o,
   output logic       tx_done_o
);
   import sol_pkg::*;

   // ==========================================================
   // receive detector
   logic       rx_on;
   logic       rx_start;
   logic       train_end;
   logic       rx_on_d_ff;
   logic [7:0] idle_cnt_ff;
   logic [2:0] n_init_ff;
   logic [2:0] n_wake_ff;
   logic       init_det_ff;
   logic       wake_det_ff;
   logic       init_end_ff;
   logic       wake_end_ff;

   assign rx_on     = link.d2h_burst && sol_is_oob_word(link.d2h_dword);
   assign rx_start  = rx_on && !rx_on_d_ff;
   assign train_end = !rx_on && (idle_cnt_ff == `SOL_GAP_MAX_CYC);

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rx_on_d_ff  <= 1'b0;
         idle_cnt_ff <= `SOL_TAIL_CYC;
      end else begin
         rx_on_d_ff <= rx_on;
         if (rx_on) begin
            idle_cnt_ff <= 8'h00;
         end else if (idle_cnt_ff < `SOL_TAIL_CYC) begin
            idle_cnt_ff <= idle_cnt_ff + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || train_end) begin
         n_init_ff <= 3'h0;
         n_wake_ff <= 3'h0;
      end else if (rx_start) begin
         n_init_ff <= 3'h1;
         n_wake_ff <= 3'h1;
         if (idle_cnt_ff < `SOL_TAIL_CYC && sol_gap_long(idle_cnt_ff)) begin
            n_init_ff <= (n_init_ff == `SOL_DET_BURSTS) ? n_init_ff : n_init_ff + 3'h1;
         end else if (sol_gap_short(idle_cnt_ff)) begin
            n_wake_ff <= (n_wake_ff == `SOL_DET_BURSTS) ? n_wake_ff : n_wake_ff + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         init_det_ff <= 1'b0;
         wake_det_ff <= 1'b0;
         init_end_ff <= 1'b0;
         wake_end_ff <= 1'b0;
      end else begin
         init_end_ff <= train_end && init_det_ff;
         wake_end_ff <= train_end && wake_det_ff;
         if (train_end) begin
            init_det_ff <= 1'b0;
            wake_det_ff <= 1'b0;
         end else if (rx_start) begin
            init_det_ff <= sol_gap_long(idle_cnt_ff) &&
                           (n_init_ff >= `SOL_DET_BURSTS - 3'h1);
            wake_det_ff <= sol_gap_short(idle_cnt_ff) &&
                           (n_wake_ff >= `SOL_DET_BURSTS - 3'h1);
         end
      end
   end

   // ==========================================================
   // pending requests, set wins over take
   logic     pend_rst_ff;
   logic     pend_wake_ff;
   logic     take;
   sol_oob_t take_kind;

   assign take_kind = pend_rst_ff ? SOL_OOB_RSTINIT : SOL_OOB_WAKE;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pend_rst_ff  <= 1'b0;
         pend_wake_ff <= 1'b0;
      end else begin
         if (send_reset_i) begin
            pend_rst_ff <= 1'b1;
         end else if (take && take_kind == SOL_OOB_RSTINIT) begin
            pend_rst_ff <= 1'b0;
         end
         if (send_wake_i || init_end_ff) begin
            pend_wake_ff <= 1'b1;
         end else if (take && take_kind == SOL_OOB_WAKE) begin
            pend_wake_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // transmit sequencer
   sol_tx_st_t  state_ff;
   sol_tx_st_t  nxt_state;
   logic [7:0]  cnt_ff;
   logic [2:0]  nb_ff;
   sol_oob_t    kind_ff;
   logic        d243_ff;
   logic        tx_burst_ff;
   logic [31:0] tx_dword_ff;
   logic        busy_ff;
   logic        done_ff;
   logic        last;
   logic [7:0]  gap_len;

   assign gap_len = (kind_ff == SOL_OOB_WAKE) ? `SOL_WAKE_GAP_CYC : `SOL_GAP_CYC;

   always_comb begin
      nxt_state = state_ff;
      take      = 1'b0;
      last      = 1'b0;
      case (state_ff)
         SOL_TX_IDLE: begin
            take      = pend_rst_ff || pend_wake_ff;
            nxt_state = take ? SOL_TX_BURST : SOL_TX_IDLE;
         end
         SOL_TX_BURST: begin
            last = (cnt_ff == `SOL_BURST_CYC - 8'h01);
            if (last) begin
               nxt_state = (nb_ff == `SOL_TX_BURSTS) ? SOL_TX_TAIL : SOL_TX_GAP;
            end
         end
         SOL_TX_GAP: begin
            last      = (cnt_ff == gap_len - 8'h01);
            nxt_state = last ? SOL_TX_BURST : SOL_TX_GAP;
         end
         SOL_TX_TAIL: begin
            last      = (cnt_ff == `SOL_TAIL_CYC - 8'h01);
            nxt_state = last ? SOL_TX_IDLE : SOL_TX_TAIL;
         end
         default: begin
            nxt_state = SOL_TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_ff <= SOL_TX_IDLE;
         cnt_ff   <= 8'h00;
         nb_ff    <= 3'h0;
         kind_ff  <= SOL_OOB_RSTINIT;
         d243_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= (last || state_ff == SOL_TX_IDLE) ? 8'h00 : cnt_ff + 8'h01;
         if (take) begin
            nb_ff   <= 3'h1;
            kind_ff <= take_kind;
            d243_ff <= use_d243_i;
         end else if (state_ff == SOL_TX_GAP && last) begin
            nb_ff <= nb_ff + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         tx_burst_ff <= 1'b0;
         tx_dword_ff <= `SOL_IDLE_DW;
         busy_ff     <= 1'b0;
         done_ff     <= 1'b0;
      end else begin
         tx_burst_ff <= (nxt_state == SOL_TX_BURST);
         tx_dword_ff <= (nxt_state != SOL_TX_BURST) ? `SOL_IDLE_DW :
                        d243_ff ? `SOL_D243_DW : `SOL_ALIGN_DW;
         busy_ff     <= (nxt_state != SOL_TX_IDLE);
         done_ff     <= (state_ff == SOL_TX_TAIL) && last;
      end
   end

   // ==========================================================
   // outputs
   assign link.h2d_burst = tx_burst_ff;
   assign link.h2d_dword = tx_dword_ff;
   assign init_det_o     = init_det_ff;
   assign init_end_o     = init_end_ff;
   assign wake_det_o     = wake_det_ff;
   assign wake_end_o     = wake_end_ff;
   assign tx_busy_o      = busy_ff;
   assign tx_done_o      = done_ff;
endmodule

// >>> verif/sol_link_monitor.sv
// checker of burst words, burst lengths and gaps on both lanes
`include "sol_consts.svh"
module sol_link_monitor (
   // clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   // lanes
   input  wire logic        h2d_burst,
   input  wire logic [31:0] h2d_dword,
   input  wire logic        d2h_burst,
   input  wire logic [31:0] d2h_dword
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BC = `SOL_BURST_CYC;
   localparam int GC = `SOL_GAP_CYC;
   localparam int WC = `SOL_WAKE_GAP_CYC;
   localparam int MX = `SOL_GAP_MAX_CYC;
   logic [7:0] hb_ff;
   logic [7:0] db_ff;
   logic [7:0] hg_ff;
   logic [7:0] dg_ff;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // ==========================================================
   // run lengths, gap counters saturate
   always_ff @(posedge clk_sys_i) begin
      hb_ff <= (sys_rst_i || !h2d_burst) ? 8'h00 : hb_ff + 8'h01;
      db_ff <= (sys_rst_i || !d2h_burst) ? 8'h00 : db_ff + 8'h01;
      hg_ff <= sys_rst_i ? 8'hFF : h2d_burst ? 8'h00 : hg_ff + {7'h00, hg_ff != 8'hFF};
      dg_ff <= sys_rst_i ? 8'hFF : d2h_burst ? 8'h00 : dg_ff + {7'h00, dg_ff != 8'hFF};
   end
   // ==========================================================
   // assertions
   h_word_a: assert property (h2d_burst |-> h2d_dword inside {`SOL_ALIGN_DW, `SOL_D243_DW})
      else $error("host lane burst word wrong");
   d_word_a: assert property (d2h_burst |-> d2h_dword inside {`SOL_ALIGN_DW, `SOL_D243_DW})
      else $error("device lane burst word wrong");
   h_idle_a: assert property (!h2d_burst |-> h2d_dword == `SOL_IDLE_DW)
      else $error("host lane gap not idle");
   d_idle_a: assert property (!d2h_burst |-> d2h_dword == `SOL_IDLE_DW)
      else $error("device lane gap not idle");
   h_len_a: assert property ($fell(h2d_burst) |-> hb_ff == BC)
      else $error("host burst length wrong");
   d_len_a: assert property ($fell(d2h_burst) |-> db_ff == BC)
      else $error("device burst length wrong");
   h_gap_a: assert property ($rose(h2d_burst) |-> hg_ff == GC || hg_ff == WC || hg_ff > MX)
      else $error("host gap length wrong");
   d_gap_a: assert property ($rose(d2h_burst) |-> dg_ff == GC || dg_ff == WC || dg_ff > MX)
      else $error("device gap length wrong");
   d_min_a: assert property ($rose(d2h_burst) |-> d2h_burst [*8])
      else $error("device burst cut short");
endmodule

// >>> verif/sol_serial_link_oob_signaling_bench.sv
// testbench joining host and device ends, plus a driven second device
`include "sol_consts.svh"
module sol_serial_link_oob_signaling_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import sol_pkg::*;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic h_rst = 1'b0, h_wake = 1'b0, d_init = 1'b0, d_wake = 1'b0, d243 = 1'b0;
   logic pm_p = 1'b0, pm_s = 1'b0, hp = 1'b0, seen_det = 1'b0, seen_end = 1'b0;
   logic seen_hd = 1'b0, seen_dd = 1'b0;
   logic d_rdet, d_rend, d_wdet, d_wend, d_busy, d_done, e_rdet, e_rend;
   logic h_idet, h_iend, h_wdet, h_wend, h_busy, h_done;
   sol_pm_t d_pm;
   int n_fail = 0, cmp_count = 0, nh = 0;
   sol_link_if if1 ();
   sol_link_if if2 ();
   always #2.5 clk_sys_i = ~clk_sys_i;
   // ==========================================================
   // instances
   sol_host_end sol_host_end_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .link(if1.host), .send_reset_i(h_rst), .send_wake_i(h_wake), .use_d243_i(d243),
      .init_det_o(h_idet), .init_end_o(h_iend), .wake_det_o(h_wdet), .wake_end_o(h_wend),
      .tx_busy_o(h_busy), .tx_done_o(h_done));
   sol_dev_end sol_dev_end_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .link(if1.dev), .send_init_i(d_init), .send_wake_i(d_wake), .use_d243_i(d243),
      .pm_partial_i(pm_p), .pm_slumber_i(pm_s), .rst_det_o(d_rdet), .rst_end_o(d_rend),
      .wake_det_o(d_wdet), .wake_end_o(d_wend), .tx_busy_o(d_busy), .tx_done_o(d_done),
      .pm_state_o(d_pm));
   sol_dev_end sol_dev_end_inst_2 (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .link(if2.dev), .send_init_i(1'b0), .send_wake_i(1'b0), .use_d243_i(d243),
      .pm_partial_i(1'b0), .pm_slumber_i(1'b0), .rst_det_o(e_rdet), .rst_end_o(e_rend),
      .wake_det_o(), .wake_end_o(), .tx_busy_o(), .tx_done_o(), .pm_state_o());
   sol_link_monitor sol_link_monitor_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .h2d_burst(if1.h2d_burst), .h2d_dword(if1.h2d_dword),
      .d2h_burst(if1.d2h_burst), .d2h_dword(if1.d2h_dword));
   // ==========================================================
   // burst counting and detector flags
   always @(negedge clk_sys_i) begin
      if (if1.h2d_burst === 1'b1 && hp === 1'b0) nh++;
      hp = if1.h2d_burst;
      if (e_rdet === 1'b1) seen_det = 1'b1;
      if (e_rend === 1'b1) seen_end = 1'b1;
      if (h_done === 1'b1) seen_hd = 1'b1;
      if (d_done === 1'b1) seen_dd = 1'b1;
   end
   // ==========================================================
   // helpers
   task automatic chk_bit(string nm, logic e, logic g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_val(string nm, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic wt(string nm, ref logic s);
      for (int i = 0; i < 2000 && s !== 1'b1; i++) @(negedge clk_sys_i);
      chk_bit(nm, 1'b1, s);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_sys_i);
      s = 1'b0;
   endtask
   task automatic quiet();
      int q = 0;
      for (int i = 0; i < 3000 && q < 130; i++) begin
         @(negedge clk_sys_i);
         q = (h_busy !== 1'b0 || d_busy !== 1'b0) ? 0 : q + 1;
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic t_chain();
      nh = 0;
      seen_hd = 1'b0;
      seen_dd = 1'b0;
      pulse(h_rst);
      wt("dev reset seen", d_rdet);
      chk_val("bursts at detect", 8'h04, 8'(nh));
      wt("dev reset end", d_rend);
      chk_val("reset bursts", 8'h06, 8'(nh));
      wt("host init seen", h_idet);
      wt("host init end", h_iend);
      wt("dev wake seen", d_wdet);
      wt("host wake seen", h_wdet);
      wt("host wake end", h_wend);
      quiet();
      chk_bit("host train done", 1'b1, seen_hd);
      chk_bit("dev train done", 1'b1, seen_dd);
      chk_bit("busy after chain", 1'b0, h_busy | d_busy);
      chk_val("pm after chain", 8'(SOL_PM_ACTIVE), 8'(d_pm));
      $display("test chain done");
   endtask
   task automatic t_power(logic slp, logic w);
      pm_p = ~slp;
      pm_s = slp;
      d243 = w;
      repeat (4) @(negedge clk_sys_i);
      pm_p = 1'b0;
      pm_s = 1'b0;
      chk_val("pm down", slp ? 8'(SOL_PM_SLUMBER) : 8'(SOL_PM_PARTIAL), 8'(d_pm));
      pulse(h_wake);
      wt("dev wake end", d_wend);
      chk_val("pm up", 8'(SOL_PM_ACTIVE), 8'(d_pm));
      quiet();
      $display("test power done");
   endtask
   task automatic t_dev_req();
      pulse(d_init);
      wt("host init by dev", h_idet);
      quiet();
      pm_s = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      pm_s = 1'b0;
      chk_val("pm slumber", 8'(SOL_PM_SLUMBER), 8'(d_pm));
      pulse(d_wake);
      wt("host wake by dev", h_wdet);
      chk_val("pm own wake", 8'(SOL_PM_ACTIVE), 8'(d_pm));
      quiet();
      $display("test dev request done");
   endtask
   task automatic t_gap(int n, int gap, logic [31:0] w, logic e);
      seen_det = 1'b0;
      seen_end = 1'b0;
      for (int k = 0; k < n; k++) begin
         if2.h2d_burst = 1'b1;
         if2.h2d_dword = w;
         repeat (`SOL_BURST_CYC) @(negedge clk_sys_i);
         if2.h2d_burst = 1'b0;
         if2.h2d_dword = `SOL_IDLE_DW;
         repeat (k < n - 1 ? gap : 130) @(negedge clk_sys_i);
      end
      chk_bit("reset seen", e, seen_det);
      chk_bit("reset end", e, seen_end);
      $display("test gap %0d done", gap);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      if2.h2d_burst = 1'b0;
      if2.h2d_dword = `SOL_IDLE_DW;
      repeat (12) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      @(negedge clk_sys_i);
      t_chain();
      t_power(1'b0, 1'b1);
      t_power(1'b1, 1'b0);
      t_dev_req();
      t_gap(4, 64, `SOL_ALIGN_DW, 1'b1);
      t_gap(3, 64, `SOL_ALIGN_DW, 1'b0);
      t_gap(4, 34, `SOL_D243_DW, 1'b0);
      t_gap(4, 35, `SOL_D243_DW, 1'b1);
      t_gap(4, 100, `SOL_ALIGN_DW, 1'b1);
      t_gap(4, 110, `SOL_ALIGN_DW, 1'b0);
      t_gap(4, 64, 32'h12345678, 1'b0);
      report_and_stop();
   end
   initial begin
      repeat (40000) @(posedge clk_sys_i);
      n_fail++;
      $display("[FAIL] watchdog expected end seen hang");
      report_and_stop();
   end
endmodule
